// file: can_stamp_vector.sv
// CAN timestamp control, interrupt vector codes and enables on Avalon-MM.
// Function
// R1 - Counter steps each prescale period while running
// R2 - Run cleared halts counter and zeroes it
// R3 - Counter write clears prescaler, keeps setting
// R4 - Prescale N steps every N+1 clocks
// R5 - End-of-frame select stamps when frame valid
// R6 - Otherwise classical frames stamp at start-of-frame
// R7 - FD select stamps after FDF bit
// R8 - Receive code: none, or FIFO 1..7
// R9 - Transmit code: none, or FIFO 0..7
// R10 - Report matched filter number 0..15
// R11 - Event codes for attempt, queue, invalid, mode, timer
// R12 - Event codes for address, overflow, wake, error, none
// R13 - Assembly buffer failure has its own code
// R14 - FIFO event codes from transmit or receive flags
// R15 - Writable enable for every event source
// R16 - Codes read-only, unused bits read zero
// R17 - Counter is 32 bits, upper half alike
// R18 - Overflow flag set when counter wraps
// R19 - Hardware sets event flags, software clears
// R20 - Highest pending enabled code wins, tracks clears
// R21 - Interrupt request when flag and enable set
//
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module can_stamp_vector (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic [5:0]  address_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [31:0] writedata_in,
  input  wire logic [3:0]  byteenable_in,
  output logic      [31:0] readdata_out,
  output logic             waitrequest_out,
  input  wire logic [7:0]  rx_fifo_flag_in,
  input  wire logic [7:0]  tx_fifo_flag_in,
  input  wire logic        tx_attempt_any_in,
  input  wire logic        tx_event_queue_any_in,
  input  wire logic        rx_overflow_any_in,
  input  wire logic        bad_message_evt_in,
  input  wire logic        wakeup_evt_in,
  input  wire logic        bus_error_evt_in,
  input  wire logic        mab_fail_evt_in,
  input  wire logic        address_error_evt_in,
  input  wire logic        mode_change_evt_in,
  input  wire logic        filter_hit_valid_in,
  input  wire logic [4:0]  matched_filter_index_in,
  input  wire logic        sof_sample_in,
  input  wire logic        fdf_next_sample_in,
  input  wire logic        frame_valid_in,
  output logic      [31:0] stamp_value_out,
  output logic             stamp_strobe_out,
  output logic             interrupt_request_out
);
  typedef struct packed {
    logic        busy;
    logic [31:0] rdata;
    logic [2:0]  ctrl;
    logic [9:0]  pre;
    logic [15:0] en;
    logic [15:0] hs;
    logic        message_assembly_buffer;
    logic        adr;
    logic [4:0]  filt;
    logic [31:0] stamp;
    logic        stb;
    logic        irq;
    logic [6:0]  rxc;
    logic [6:0]  txc;
    logic [6:0]  evc;
  } sv_state_t;

  sv_state_t   s;
  sv_state_t   next_s;
  logic        take;
  logic        wr;
  logic [15:0] wlow;
  logic [15:0] flags;
  logic [15:0] pend;
  logic [7:0]  fifo_req;
  logic        load_low;
  logic        load_high;
  logic [31:0] tb_count;
  logic        tb_wrap;
  logic [15:0] hs_set;

  // Highest set index of an 8-bit flag vector as a vector code.
  function automatic logic [6:0] fifo_code(input logic [7:0] v);
    logic [6:0] c;
    c = can_tsiv_pkg::CODE_NONE;
    for (int i = 0; i < can_tsiv_pkg::FIFO_N; i++) begin
      if (v[i]) begin
        c = {4'h0, 3'(i)};
      end
    end
    return c;
  endfunction

  // Byte-lane merge of the low half of a write into a 16-bit register.
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  be);
    logic [15:0] m;
    m = old_v;
    if (be[0]) begin
      m[7:0] = new_v[7:0];
    end
    if (be[1]) begin
      m[15:8] = new_v[15:8];
    end
    return m;
  endfunction

  // A request is taken at the edge where waitrequest is already low.
  assign take      = !s.busy && (read_in || write_in);
  assign wr        = take && write_in;
  assign load_low  = wr && (address_in == can_tsiv_pkg::OFF_TBC_LOW);
  assign load_high = wr && (address_in == can_tsiv_pkg::OFF_TBC_HIGH);

  always_comb begin
    wlow = merge16(tb_count[15:0], writedata_in[15:0], byteenable_in[1:0]);
    if (load_high) begin
      wlow = merge16(tb_count[31:16], writedata_in[15:0], byteenable_in[1:0]);
    end
  end

  time_base_counter #(
    .PRE_W (can_tsiv_pkg::PRE_W),
    .CNT_W (can_tsiv_pkg::TBC_W)
  ) u_time_base (
    .clk_in       (clk_in),
    .resetn_in    (resetn_in),
    .run_in       (s.ctrl[can_tsiv_pkg::RUN_BIT]),
    .prescale_in  (s.pre),
    .load_low_in  (load_low),
    .load_high_in (load_high),
    .load_data_in (wlow),
    .count_out    (tb_count),
    .wrap_out     (tb_wrap)
  );

  always_comb begin
    hs_set = '0;
    hs_set[can_tsiv_pkg::B_IVM]  = bad_message_evt_in; // [R19]
    hs_set[can_tsiv_pkg::B_WAK]  = wakeup_evt_in;
    hs_set[can_tsiv_pkg::B_CERR] = bus_error_evt_in;
    hs_set[can_tsiv_pkg::B_SERR] = mab_fail_evt_in || address_error_evt_in;
    hs_set[can_tsiv_pkg::B_MOD]  = mode_change_evt_in;
    hs_set[can_tsiv_pkg::B_TBC]  = tb_wrap; // [R18]
  end

  // Level sources are mirrored live; only the sticky bits are stored.
  always_comb begin
    flags = s.hs & can_tsiv_pkg::HSC_MASK;
    flags[can_tsiv_pkg::B_RXOV] = rx_overflow_any_in;
    flags[can_tsiv_pkg::B_TXAT] = tx_attempt_any_in;
    flags[can_tsiv_pkg::B_TEF]  = tx_event_queue_any_in;
    flags[can_tsiv_pkg::B_RX]   = |rx_fifo_flag_in[7:1];
    flags[can_tsiv_pkg::B_TX]   = |tx_fifo_flag_in;
    pend = flags & s.en; // [R15]
    fifo_req = (tx_fifo_flag_in & {8{s.en[can_tsiv_pkg::B_TX]}})
             | ({rx_fifo_flag_in[7:1], 1'b0} & {8{s.en[can_tsiv_pkg::B_RX]}}); // [R14]
  end

  always_comb begin
    next_s = s;
    next_s.busy = !(s.busy && (read_in || write_in));
    next_s.stb = 1'b0;

    // Read data is latched as waitrequest drops, so it stands at the taking edge.
    if (s.busy && read_in) begin
      next_s.rdata = '0; // [R16]
      unique case (address_in)
        can_tsiv_pkg::OFF_TBC_LOW: begin
          next_s.rdata[15:0] = tb_count[15:0];
        end
        can_tsiv_pkg::OFF_TBC_HIGH: begin
          next_s.rdata[15:0] = tb_count[31:16]; // [R17]
        end
        can_tsiv_pkg::OFF_TS_HIGH: begin
          next_s.rdata[2:0] = s.ctrl;
        end
        can_tsiv_pkg::OFF_TS_LOW: begin
          next_s.rdata[9:0] = s.pre;
        end
        can_tsiv_pkg::OFF_CODE_HIGH: begin
          next_s.rdata[14:0] = {s.rxc, 1'b0, s.txc};
        end
        can_tsiv_pkg::OFF_CODE_LOW: begin
          next_s.rdata[12:0] = {s.filt, 1'b0, s.evc}; // [R10]
        end
        can_tsiv_pkg::OFF_EN_HIGH: begin
          next_s.rdata[15:0] = s.en;
        end
        can_tsiv_pkg::OFF_FLAG_LOW: begin
          next_s.rdata[15:0] = flags;
        end
        can_tsiv_pkg::OFF_STAMP: begin
          next_s.rdata = s.stamp;
        end
        default: begin
          next_s.rdata = '0;
        end
      endcase
    end

    if (wr) begin
      unique case (address_in)
        can_tsiv_pkg::OFF_TS_HIGH: begin
          next_s.ctrl = 3'(merge16({13'h0000, s.ctrl}, writedata_in[15:0],
                                   byteenable_in[1:0])); // [R2]
        end
        can_tsiv_pkg::OFF_TS_LOW: begin
          next_s.pre = 10'(merge16({6'h00, s.pre}, writedata_in[15:0],
                                   byteenable_in[1:0])); // [R4]
        end
        can_tsiv_pkg::OFF_EN_HIGH: begin
          next_s.en = merge16(s.en, writedata_in[15:0], byteenable_in[1:0])
                    & can_tsiv_pkg::EN_MASK; // [R15]
        end
        can_tsiv_pkg::OFF_FLAG_LOW: begin
          // Writing 0 clears a sticky bit; writing 1 leaves it as it is.
          next_s.hs = merge16(s.hs, writedata_in[15:0], byteenable_in[1:0])
                    & s.hs; // [R19]
        end
        default: begin
          next_s.ctrl = s.ctrl;
        end
      endcase
    end

    // An event in the clearing cycle survives the clear.
    next_s.hs = (next_s.hs | hs_set) & can_tsiv_pkg::HSC_MASK; // [R19]
    if (mab_fail_evt_in) begin
      next_s.message_assembly_buffer = 1'b1;
    end else if (!next_s.hs[can_tsiv_pkg::B_SERR]) begin
      next_s.message_assembly_buffer = 1'b0;
    end
    if (address_error_evt_in) begin
      next_s.adr = 1'b1;
    end else if (!next_s.hs[can_tsiv_pkg::B_SERR]) begin
      next_s.adr = 1'b0;
    end

    if (filter_hit_valid_in) begin
      next_s.filt = matched_filter_index_in; // [R10]
    end

    // The start-of-frame stamp of an FD frame is overwritten after FDF.
    if (s.ctrl[can_tsiv_pkg::EOF_BIT]) begin
      next_s.stb = frame_valid_in; // [R5]
    end else if (fdf_next_sample_in && s.ctrl[can_tsiv_pkg::FDSEL_BIT]) begin
      next_s.stb = 1'b1; // [R7]
    end else begin
      next_s.stb = sof_sample_in; // [R6]
    end
    if (next_s.stb) begin
      next_s.stamp = tb_count;
    end

    next_s.rxc = fifo_code({rx_fifo_flag_in[7:1], 1'b0}); // [R8]
    next_s.txc = fifo_code(tx_fifo_flag_in); // [R9]

    if (pend[can_tsiv_pkg::B_TXAT]) begin
      next_s.evc = can_tsiv_pkg::CODE_TXAT; // [R20] [R11]
    end else if (pend[can_tsiv_pkg::B_TEF]) begin
      next_s.evc = can_tsiv_pkg::CODE_TEF; // [R11]
    end else if (pend[can_tsiv_pkg::B_IVM]) begin
      next_s.evc = can_tsiv_pkg::CODE_IVM; // [R11]
    end else if (pend[can_tsiv_pkg::B_MOD]) begin
      next_s.evc = can_tsiv_pkg::CODE_MOD; // [R11]
    end else if (pend[can_tsiv_pkg::B_TBC]) begin
      next_s.evc = can_tsiv_pkg::CODE_TBC; // [R11]
    end else if (pend[can_tsiv_pkg::B_SERR] && s.message_assembly_buffer) begin
      next_s.evc = can_tsiv_pkg::CODE_MAB; // [R13]
    end else if (pend[can_tsiv_pkg::B_SERR] && s.adr) begin
      next_s.evc = can_tsiv_pkg::CODE_ADDR; // [R12]
    end else if (pend[can_tsiv_pkg::B_RXOV]) begin
      next_s.evc = can_tsiv_pkg::CODE_RXOV; // [R12]
    end else if (pend[can_tsiv_pkg::B_WAK]) begin
      next_s.evc = can_tsiv_pkg::CODE_WAK; // [R12]
    end else if (pend[can_tsiv_pkg::B_CERR]) begin
      next_s.evc = can_tsiv_pkg::CODE_CERR; // [R12]
    end else begin
      next_s.evc = fifo_code(fifo_req); // [R14]
    end

    next_s.irq = |pend; // [R21]
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      s <= '0;
      s.busy <= 1'b1;
      s.ctrl <= can_tsiv_pkg::CTRL_RST;
      s.pre <= can_tsiv_pkg::PRE_RST;
      s.en <= can_tsiv_pkg::EN_RST;
      s.filt <= can_tsiv_pkg::FILT_RST;
      s.rxc <= can_tsiv_pkg::CODE_NONE;
      s.txc <= can_tsiv_pkg::CODE_NONE;
      s.evc <= can_tsiv_pkg::CODE_NONE;
    end else begin
      s <= next_s;
    end
  end

  assign readdata_out          = s.rdata;
  assign waitrequest_out       = s.busy;
  assign stamp_value_out       = s.stamp;
  assign stamp_strobe_out      = s.stb;
  assign interrupt_request_out = s.irq;

  property p_irq;
    @(posedge clk_in) disable iff (!resetn_in)
      (|(flags & s.en)) |=> interrupt_request_out;
  endproperty
  a_irq: assert property (p_irq) else $error("request missing"); // [R21]

  property p_rx_none;
    @(posedge clk_in) disable iff (!resetn_in)
      (rx_fifo_flag_in[7:1] == 7'h00) |=> (s.rxc == can_tsiv_pkg::CODE_NONE);
  endproperty
  a_rx_none: assert property (p_rx_none) else $error("receive code not idle"); // [R8]

  property p_rx_not_zero;
    @(posedge clk_in) disable iff (!resetn_in)
      s.rxc != 7'h00;
  endproperty
  a_rx_not_zero: assert property (p_rx_not_zero) else $error("receive code zero"); // [R8]

  property p_tx_top;
    @(posedge clk_in) disable iff (!resetn_in)
      tx_fifo_flag_in[7] |=> (s.txc == 7'h07);
  endproperty
  a_tx_top: assert property (p_tx_top) else $error("transmit code wrong"); // [R9]

  property p_ev_none;
    @(posedge clk_in) disable iff (!resetn_in)
      (pend == 16'h0000) |=> (s.evc == can_tsiv_pkg::CODE_NONE);
  endproperty
  a_ev_none: assert property (p_ev_none) else $error("event code not idle"); // [R12]

  property p_ev_top;
    @(posedge clk_in) disable iff (!resetn_in)
      pend[can_tsiv_pkg::B_TXAT] |=> (s.evc == can_tsiv_pkg::CODE_TXAT);
  endproperty
  a_ev_top: assert property (p_ev_top) else $error("priority lost"); // [R20]

  property p_set_wins;
    @(posedge clk_in) disable iff (!resetn_in)
      bad_message_evt_in |=> flags[can_tsiv_pkg::B_IVM];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event flag lost"); // [R19]

  sequence s_eof_stamp;
    s.ctrl[can_tsiv_pkg::EOF_BIT] && frame_valid_in;
  endsequence
  property p_eof_stamp;
    @(posedge clk_in) disable iff (!resetn_in)
      s_eof_stamp |=> (stamp_strobe_out && stamp_value_out == $past(tb_count));
  endproperty
  a_eof_stamp: assert property (p_eof_stamp) else $error("frame end stamp missed"); // [R5]

  property p_bus_answer;
    @(posedge clk_in) disable iff (!resetn_in)
      (s.busy && (read_in || write_in)) |=> !waitrequest_out ##1 waitrequest_out;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late"); // [R16]
endmodule

// file: can_tsiv_pkg.sv
// Constants shared by the CAN timestamp and interrupt vector block.
package can_tsiv_pkg;
  localparam int PRE_W  = 10;
  localparam int TBC_W  = 32;
  localparam int CODE_W = 7;
  localparam int FIFO_N = 8;
  localparam int FILT_W = 5;
  localparam int ADDR_W = 6;

  localparam logic [ADDR_W-1:0] OFF_TBC_LOW   = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_TBC_HIGH  = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_TS_HIGH   = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_TS_LOW    = 6'h0C;
  localparam logic [ADDR_W-1:0] OFF_CODE_HIGH = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_CODE_LOW  = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_EN_HIGH   = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_FLAG_LOW  = 6'h1C;
  localparam logic [ADDR_W-1:0] OFF_STAMP     = 6'h20;

  localparam int RUN_BIT   = 0;
  localparam int EOF_BIT   = 1;
  localparam int FDSEL_BIT = 2;
  localparam int HI_LSB    = 8;

  localparam int B_IVM  = 15;
  localparam int B_WAK  = 14;
  localparam int B_CERR = 13;
  localparam int B_SERR = 12;
  localparam int B_RXOV = 11;
  localparam int B_TXAT = 10;
  localparam int B_TEF  = 4;
  localparam int B_MOD  = 3;
  localparam int B_TBC  = 2;
  localparam int B_RX   = 1;
  localparam int B_TX   = 0;

  localparam logic [15:0] EN_MASK  = 16'hFC1F;
  localparam logic [15:0] HSC_MASK = 16'hF00C;

  localparam logic [2:0]        CTRL_RST = 3'h0;
  localparam logic [PRE_W-1:0]  PRE_RST  = 10'h000;
  localparam logic [15:0]       EN_RST   = 16'h0000;
  localparam logic [FILT_W-1:0] FILT_RST = 5'h00;

  localparam logic [CODE_W-1:0] CODE_NONE = 7'h40;
  localparam logic [CODE_W-1:0] CODE_CERR = 7'h41;
  localparam logic [CODE_W-1:0] CODE_WAK  = 7'h42;
  localparam logic [CODE_W-1:0] CODE_RXOV = 7'h43;
  localparam logic [CODE_W-1:0] CODE_ADDR = 7'h44;
  localparam logic [CODE_W-1:0] CODE_MAB  = 7'h45;
  localparam logic [CODE_W-1:0] CODE_TBC  = 7'h46;
  localparam logic [CODE_W-1:0] CODE_MOD  = 7'h47;
  localparam logic [CODE_W-1:0] CODE_IVM  = 7'h48;
  localparam logic [CODE_W-1:0] CODE_TEF  = 7'h49;
  localparam logic [CODE_W-1:0] CODE_TXAT = 7'h4A;
endpackage

// file: time_base_counter.sv
// Prescaled 32-bit time base counter with run control and half loads.
`timescale 1ns/1ps
module time_base_counter #(
  parameter int PRE_W = can_tsiv_pkg::PRE_W,
  parameter int CNT_W = can_tsiv_pkg::TBC_W
) (
  input  wire logic               clk_in,
  input  wire logic               resetn_in,
  input  wire logic               run_in,
  input  wire logic [PRE_W-1:0]   prescale_in,
  input  wire logic               load_low_in,
  input  wire logic               load_high_in,
  input  wire logic [CNT_W/2-1:0] load_data_in,
  output logic      [CNT_W-1:0]   count_out,
  output logic                    wrap_out
);
  localparam int HALF = CNT_W / 2;

  typedef struct packed {
    logic [PRE_W-1:0] pcnt;
    logic [CNT_W-1:0] count;
    logic             wrap;
  } tb_state_t;

  tb_state_t s;
  tb_state_t next_s;
  logic      tick;

  // A compare with >= keeps the prescaler from running the long way round
  // when software lowers the prescale setting during a period.
  always_comb begin
    next_s = s;
    next_s.wrap = 1'b0;
    tick = run_in && (s.pcnt >= prescale_in); // [R4]
    if (!run_in) begin
      next_s.pcnt = '0; // [R2]
      next_s.count = '0; // [R2]
    end else if (load_low_in || load_high_in) begin
      next_s.pcnt = '0; // [R3]
      if (load_low_in) begin
        next_s.count[HALF-1:0] = load_data_in;
      end
      if (load_high_in) begin
        next_s.count[CNT_W-1:HALF] = load_data_in; // [R17]
      end
    end else if (tick) begin
      next_s.pcnt = '0;
      next_s.count = s.count + 1'b1; // [R1]
      next_s.wrap = &s.count; // [R18]
    end else begin
      next_s.pcnt = s.pcnt + 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign count_out = s.count;
  assign wrap_out  = s.wrap;

  property p_halt;
    @(posedge clk_in) disable iff (!resetn_in)
      !run_in |=> (count_out == '0);
  endproperty
  a_halt: assert property (p_halt) else $error("time base not cleared while stopped"); // [R2]

  sequence s_fast_run;
    run_in && !load_low_in && !load_high_in && (prescale_in == '0);
  endsequence
  property p_every_clock;
    @(posedge clk_in) disable iff (!resetn_in)
      s_fast_run ##1 s_fast_run |=> (count_out == $past(count_out) + 1'b1);
  endproperty
  a_every_clock: assert property (p_every_clock) else $error("no step per clock"); // [R4]

  property p_wrap;
    @(posedge clk_in) disable iff (!resetn_in)
      (tick && !load_low_in && !load_high_in && (&count_out)) |=> (wrap_out && count_out == '0);
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap not reported"); // [R18]

  property p_load_clears_presc;
    @(posedge clk_in) disable iff (!resetn_in)
      (run_in && load_low_in && prescale_in != '0) ##1
        (run_in && !load_low_in && !load_high_in && prescale_in != '0)
        |=> (count_out == $past(count_out));
  endproperty
  a_load_clears_presc: assert property (p_load_clears_presc) else $error("prescaler kept"); // [R3]
endmodule

// file: can_engine_model.sv
// Behavioural protocol engine that drives FIFO flags, event pulses and stamp points.
`timescale 1ns/1ps
module can_engine_model (
  input  wire logic       clk_in,
  output logic      [7:0] rx_fifo_flag_out,
  output logic      [7:0] tx_fifo_flag_out,
  output logic      [2:0] level_out,
  output logic      [9:0] pulse_out,
  output logic      [4:0] filter_out
);
  initial begin
    rx_fifo_flag_out = 8'h00;
    tx_fifo_flag_out = 8'h00;
    level_out = 3'h0;
    pulse_out = 10'h000;
    filter_out = 5'h00;
  end

  // Ids below 10 are one-clock pulses, 10 to 12 raise a live level.
  task automatic fire(input int i, input logic [4:0] f = 5'h00);
    if (i >= 10) begin
      level_out[i-10] <= 1'b1;
    end else begin
      filter_out <= f;
      pulse_out <= 10'h001 << i;
      @(posedge clk_in);
      pulse_out <= 10'h000;
      // The index is not held after its pulse, so a late latch reads garbage.
      filter_out <= ~f;
    end
  endtask

  task automatic set_flags(input logic [7:0] rx, input logic [7:0] tx, input logic [2:0] lv);
    rx_fifo_flag_out <= rx;
    tx_fifo_flag_out <= tx;
    level_out <= lv;
  endtask
endmodule

// file: can_stamp_vector_tb.sv
// Self-checking bench for the CAN timestamp and interrupt vector block.
`timescale 1ns/1ps
module can_stamp_vector_tb;
  logic        clk_in;
  logic        resetn_in;
  logic [5:0]  address_in;
  logic        read_in;
  logic        write_in;
  logic [31:0] writedata_in;
  logic [31:0] readdata_out;
  logic        waitrequest_out;
  logic [31:0] stamp_value_out;
  logic        stamp_strobe_out;
  logic        interrupt_request_out;
  logic [7:0]  rxf;
  logic [7:0]  txf;
  logic [2:0]  lv;
  logic [9:0]  pl;
  logic [4:0]  fi;
  int          miscompares;
  int          checks;
  logic [31:0] q;
  logic [31:0] l;
  logic [31:0] last;
  logic [7:0]  rx;
  logic [7:0]  tx;
  logic [4:0]  f;
  int          n;
  int          m;
  int unsigned seed;
  int          ctl[5] = '{1, 1, 5, 3, 3};
  int          pid[5] = '{6, 7, 7, 6, 8};
  bit          hit[5] = '{1, 0, 1, 0, 1};
  int          src[9] = '{2, 1, 12, 4, 3, 5, 0, 11, 10};
  logic [6:0]  code[9] = '{7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h47, 7'h48, 7'h49, 7'h4A};

  can_engine_model u_can_engine_model (
    .clk_in(clk_in), .rx_fifo_flag_out(rxf), .tx_fifo_flag_out(txf),
    .level_out(lv), .pulse_out(pl), .filter_out(fi)
  );

  can_stamp_vector u_can_stamp_vector (
    .clk_in(clk_in), .resetn_in(resetn_in), .address_in(address_in), .read_in(read_in),
    .write_in(write_in), .writedata_in(writedata_in), .byteenable_in(4'h3),
    .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
    .rx_fifo_flag_in(rxf), .tx_fifo_flag_in(txf), .tx_attempt_any_in(lv[0]),
    .tx_event_queue_any_in(lv[1]), .rx_overflow_any_in(lv[2]),
    .bad_message_evt_in(pl[0]), .wakeup_evt_in(pl[1]), .bus_error_evt_in(pl[2]),
    .mab_fail_evt_in(pl[3]), .address_error_evt_in(pl[4]), .mode_change_evt_in(pl[5]),
    .filter_hit_valid_in(pl[9]), .matched_filter_index_in(fi), .sof_sample_in(pl[6]),
    .fdf_next_sample_in(pl[7]), .frame_valid_in(pl[8]), .stamp_value_out(stamp_value_out),
    .stamp_strobe_out(stamp_strobe_out), .interrupt_request_out(interrupt_request_out)
  );

  always #12.5 clk_in = ~clk_in;

  function automatic logic [6:0] hi(input logic [7:0] v);
    hi = 7'h40;
    for (int i = 0; i < 8; i++) begin
      if (v[i]) hi = 7'(i);
    end
  endfunction

  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon transfer; the extra edge keeps back-to-back calls from redriving a strobe.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] d);
    int k;
    k = 0;
    read_in <= ~wr;
    write_in <= wr;
    address_in <= a;
    writedata_in <= {16'h0000, d};
    @(posedge clk_in);
    while (waitrequest_out !== 1'b0 && k < 20) begin
      @(posedge clk_in);
      k++;
    end
    if (k >= 20) miscompares++;
    q = readdata_out;
    read_in <= 1'b0;
    write_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 16'h0000);
    chk(q, exp);
  endtask

  task automatic irq(input logic e);
    chk({31'h0, interrupt_request_out}, {31'h0, e});
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    end_sim();
  end

  initial begin
    clk_in = 1'b0;
    resetn_in = 1'b0;
    address_in = 6'h00;
    read_in = 1'b0;
    write_in = 1'b0;
    writedata_in = 32'h0000_0000;
    miscompares = 0;
    checks = 0;
    seed = $urandom(32'h9CC0);
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    rd(6'h08, 0);
    rd(6'h10, 32'h4040);
    rd(6'h14, 32'h0040);
    rd(6'h3C, 0);
    bus(1'b1, 6'h10, 16'($urandom));
    rd(6'h10, 32'h4040);
    l = $urandom;
    bus(1'b1, 6'h18, l[15:0]);
    rd(6'h18, {16'h0000, l[15:0] & can_tsiv_pkg::EN_MASK});
    $display("test registers done");
    bus(1'b1, 6'h00, 16'h1234);
    rd(6'h00, 0);
    last = 0;
    for (int k = 0; k < 5; k++) begin
      n = $urandom % 4;
      m = 2 + $urandom % 20;
      l = $urandom % 32'hF000;
      bus(1'b1, 6'h08, 16'(ctl[k]));
      bus(1'b1, 6'h0C, 16'(n));
      bus(1'b1, 6'h04, 16'h0000);
      bus(1'b1, 6'h00, l[15:0]);
      repeat (m - 1) @(posedge clk_in);
      u_can_engine_model.fire(pid[k]);
      if (hit[k]) last = l + 32'(m / (n + 1));
      @(posedge clk_in);
      chk({31'h0, stamp_strobe_out}, {31'h0, hit[k]});
      repeat (2) @(posedge clk_in);
      chk(stamp_value_out, last);
      rd(6'h20, last);
    end
    bus(1'b1, 6'h08, 16'h0000);
    rd(6'h20, last);
    rd(6'h00, 0);
    $display("test stamps done");
    bus(1'b1, 6'h08, 16'h0001);
    bus(1'b1, 6'h0C, 16'h0000);
    bus(1'b1, 6'h18, 16'h0000);
    bus(1'b1, 6'h1C, 16'h0000);
    bus(1'b1, 6'h04, 16'hFFFF);
    bus(1'b1, 6'h00, 16'hFFFF);
    repeat (4) @(posedge clk_in);
    rd(6'h1C, 32'h0004);
    rd(6'h04, 0);
    bus(1'b1, 6'h18, 16'h0004);
    repeat (3) @(posedge clk_in);
    rd(6'h14, 32'h0046);
    irq(1'b1);
    bus(1'b1, 6'h1C, 16'h0000);
    repeat (3) @(posedge clk_in);
    rd(6'h14, 32'h0040);
    irq(1'b0);
    $display("test overflow done");
    bus(1'b1, 6'h18, 16'h0003);
    for (int k = 0; k < 16; k++) begin
      rx = (k == 0 || k == 1) ? 8'h00 : 8'($urandom);
      tx = (k == 0) ? 8'h00 : (k == 1) ? 8'h01 : 8'($urandom);
      u_can_engine_model.set_flags(rx, tx, 3'h0);
      repeat (3) @(posedge clk_in);
      rd(6'h10, {16'h0000, 1'b0, hi(rx & 8'hFE), 1'b0, hi(tx)});
      rd(6'h14, {25'h0, hi(tx | (rx & 8'hFE))});
      irq((tx | (rx & 8'hFE)) != 8'h00);
    end
    u_can_engine_model.set_flags(8'h00, 8'h00, 3'h0);
    $display("test fifo codes done");
    bus(1'b1, 6'h18, can_tsiv_pkg::EN_MASK);
    for (int k = 0; k < 9; k++) begin
      u_can_engine_model.fire(src[k]);
      repeat (3) @(posedge clk_in);
      rd(6'h14, {25'h0, code[k]});
    end
    irq(1'b1);
    u_can_engine_model.set_flags(8'h00, 8'h00, 3'h0);
    bus(1'b1, 6'h1C, 16'h0000);
    repeat (3) @(posedge clk_in);
    rd(6'h14, 32'h0040);
    rd(6'h1C, 0);
    irq(1'b0);
    bus(1'b1, 6'h18, 16'h0000);
    u_can_engine_model.fire(2);
    repeat (3) @(posedge clk_in);
    rd(6'h1C, 32'h2000);
    rd(6'h14, 32'h0040);
    irq(1'b0);
    bus(1'b1, 6'h18, 16'h2000);
    repeat (3) @(posedge clk_in);
    rd(6'h14, 32'h0041);
    irq(1'b1);
    $display("test event codes done");
    bus(1'b1, 6'h18, 16'h0000);
    bus(1'b1, 6'h1C, 16'h0000);
    f = 5'($urandom % 16);
    u_can_engine_model.fire(9, f);
    repeat (3) @(posedge clk_in);
    rd(6'h14, {16'h0000, 3'b000, f, 1'b0, 7'h40});
    $display("test filter done");
    end_sim();
  end
endmodule
